//--- common/fwm_pkg.sv
// Constants shared by the fieldbus fault and warning monitor
package fwm_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // Half period of the link-error blink, in milliseconds
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  // Warm-up cycles before the switches are latched (one more than the two-stage synchroniser depth)
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // Switch limits
  localparam logic [3:0] BAUD_MAX = 4'h4;
  localparam logic [6:0] STN_MIN = 7'h01;
  localparam logic [6:0] STN_MAX = 7'h40;
  localparam logic [3:0] BCD_MAX = 4'h9;
  // Warning and alarm codes
  localparam logic [7:0] WCODE_ERR = 8'h84;
  localparam logic [7:0] WCODE_TMO = 8'h85;
  localparam logic [7:0] ACODE_ERR = 8'h84;
  localparam logic [1:0] ERR_LIMIT = 2'h3;
  localparam int HIST_DEPTH = 10;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_HCNT = 8'h08;
  localparam logic [7:0] OFS_SWITCH = 8'h0c;
  localparam logic [7:0] OFS_ALARM = 8'h10;
  localparam logic [7:0] OFS_HIST0 = 8'h20;
  // Control fields
  localparam int CTRL_HCLR_BIT = 0;
  localparam int CTRL_INHIBIT_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status fields
  localparam int ST_WARN = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_STOP = 2;
  localparam int ST_RUN = 3;
  localparam int ST_LERR = 4;
  localparam int ST_SETERR = 5;
  localparam int ST_MISMATCH = 6;
  localparam int ST_DISC = 7;
  localparam int ST_W84 = 8;
  localparam int ST_W85 = 9;
  // Pin vector layout after the synchroniser
  localparam int PIN_W = 19;
  typedef enum logic [1:0] {
    FWM_LINK_IDLE = 2'b01,
    FWM_LINK_DEAD = 2'b10
  } fwm_ds_type;
endpackage : fwm_pkg

//--- verilog/fwm_monitor.sv
// Fault, warning and link indicator supervision with AHB-Lite registers
// How it works
// - Any upstream fieldbus error stops all motors until it clears.
// - Controller program halt while running stops motor operation.
// - Run indicator off on master halt, duplicate station, cable fault.
// - Baud switch above 4 is a setting error: run off, error lit.
// - Station switch outside 01..64 is a setting error on indicators.
// - Switch change while operating blinks the link-error indicator.
// - Fieldbus receive errors light the link-error indicator steadily.
// - Any warning sets the warning flag; motors keep running.
// - Warning and flag clear by themselves once the cause is gone.
// - Ten newest warning codes kept, newest first, readable, clearable.
// - History lives in flops only, so power loss empties it.
// - Downstream transaction error raises warning 84h.
// - Downstream response not complete in its cycle raises warning 85h.
// - Upstream link loss reports disconnected, raises no alarm itself.
// - Three consecutive downstream errors: alarm 84h, stop traffic.
// - Any alarm sets the alarm flag.
`timescale 1ns/1ps
module fwm_monitor #(
  parameter int BLINK_CYC = fwm_pkg::BLINK_HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] baud_sw,
  input wire logic [3:0] stn_tens_sw,
  input wire logic [3:0] stn_ones_sw,
  input wire logic up_comm_err,
  input wire logic plc_halt,
  input wire logic sys_running,
  input wire logic master_halt,
  input wire logic dup_station,
  input wire logic cable_fault,
  input wire logic rx_err,
  input wire logic ds_ok,
  input wire logic ds_err,
  input wire logic ds_timeout,
  output logic motor_stop,
  output logic link_run_led,
  output logic link_err_led,
  output logic warning_flag,
  output logic alarm_flag,
  output logic link_disc,
  output logic rs485_stop
);
  // Pin synchroniser: first stage feeds only the second stage
  logic [fwm_pkg::PIN_W-1:0] pin_raw, pin_m_q, pin_s_q;
  assign pin_raw = {baud_sw, stn_tens_sw, stn_ones_sw, up_comm_err,
                    plc_halt, sys_running, master_halt, dup_station,
                    cable_fault, rx_err};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else if (ce) begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
    end
  end
  logic [11:0] sw_live;
  logic s_uperr, s_halt, s_run, s_mhalt, s_dup, s_cable, s_rxerr;
  assign sw_live = pin_s_q[18:7];
  assign {s_uperr, s_halt, s_run, s_mhalt, s_dup, s_cable, s_rxerr} =
    pin_s_q[6:0];

  function automatic logic stn_bad(input logic [7:0] bcd);
    logic [6:0] v;
    // Widen the tens digit first so the product cannot wrap at four bits
    v = 7'(bcd[7:4]) * 7'h0a + 7'(bcd[3:0]);
    stn_bad = (bcd[7:4] > fwm_pkg::BCD_MAX) ||
              (bcd[3:0] > fwm_pkg::BCD_MAX) ||
              (v < fwm_pkg::STN_MIN) || (v > fwm_pkg::STN_MAX);
  endfunction : stn_bad

  // Switch latch, setting check and blink
  logic [1:0] wait_q, wait_d;
  logic latched_q, latched_d;
  logic [11:0] sw_q, sw_d;
  logic [23:0] blink_cnt_q, blink_cnt_d;
  logic blink_q, blink_d;
  logic set_err, mismatch;
  assign set_err = latched_q && ((sw_q[11:8] > fwm_pkg::BAUD_MAX) ||
                   stn_bad(sw_q[7:0]));
  assign mismatch = latched_q && (sw_live != sw_q);
  always_comb begin
    wait_d = wait_q;
    latched_d = latched_q;
    sw_d = sw_q;
    blink_cnt_d = blink_cnt_q;
    blink_d = blink_q;
    if (!latched_q) begin
      if (wait_q == fwm_pkg::STRAP_WAIT) begin
        latched_d = 1'b1;
        sw_d = sw_live;
      end else begin
        wait_d = wait_q + 2'h1;
      end
    end
    if (blink_cnt_q >= 24'(BLINK_CYC - 1)) begin
      blink_cnt_d = '0;
      blink_d = ~blink_q;
    end else begin
      blink_cnt_d = blink_cnt_q + 24'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= '0;
      latched_q <= 1'b0;
      sw_q <= '0;
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (ce) begin
      wait_q <= wait_d;
      latched_q <= latched_d;
      sw_q <= sw_d;
      blink_cnt_q <= blink_cnt_d;
      blink_q <= blink_d;
    end
  end

  // Bus register state
  logic [31:0] ctrl_q, ctrl_d;
  logic hclr;

  // Downstream warnings, error run and alarm
  fwm_pkg::fwm_ds_type ds_q, ds_d;
  logic w84_q, w84_d, w85_q, w85_d;
  logic [1:0] run_q, run_d;
  logic [7:0] hist_q [fwm_pkg::HIST_DEPTH];
  logic [7:0] hist_d [fwm_pkg::HIST_DEPTH];
  logic [3:0] hcnt_q, hcnt_d;
  logic push;
  logic [7:0] push_code;
  logic ds_fail;
  assign ds_fail = ds_err || ds_timeout;
  always_comb begin
    ds_d = ds_q;
    w84_d = w84_q;
    w85_d = w85_q;
    run_d = run_q;
    push = 1'b0;
    push_code = fwm_pkg::WCODE_ERR;
    unique case (ds_q)
      fwm_pkg::FWM_LINK_IDLE: begin
        if (ds_ok) begin
          w84_d = 1'b0;
          w85_d = 1'b0;
          run_d = '0;
        end
        if (ds_err) w84_d = 1'b1;
        if (ds_timeout) w85_d = 1'b1;
        if (ds_err && !w84_q) begin
          push = 1'b1;
        end else if (ds_timeout && !w85_q) begin
          push = 1'b1;
          push_code = fwm_pkg::WCODE_TMO;
        end
        if (ds_fail) begin
          run_d = run_q + 2'h1;
          if (run_d == fwm_pkg::ERR_LIMIT) begin
            ds_d = fwm_pkg::FWM_LINK_DEAD;
            w84_d = 1'b0;
            w85_d = 1'b0;
          end
        end
      end
      // Only a power cycle leaves this state
      fwm_pkg::FWM_LINK_DEAD: ds_d = fwm_pkg::FWM_LINK_DEAD;
      default: ds_d = fwm_pkg::FWM_LINK_DEAD;
    endcase
    hcnt_d = hcnt_q;
    for (int i = 0; i < fwm_pkg::HIST_DEPTH; i++) hist_d[i] = hist_q[i];
    if (push) begin
      hist_d[0] = push_code;
      for (int i = 1; i < fwm_pkg::HIST_DEPTH; i++)
        hist_d[i] = hist_q[i-1];
      if (hcnt_q != 4'(fwm_pkg::HIST_DEPTH)) hcnt_d = hcnt_q + 4'h1;
    end else if (hclr) begin
      hcnt_d = '0;
      for (int i = 0; i < fwm_pkg::HIST_DEPTH; i++) hist_d[i] = '0;
    end
  end
  // History and counters reset to zero, ds_q to FWM_LINK_IDLE: contents vanish with power
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ds_q <= fwm_pkg::FWM_LINK_IDLE;
      w84_q <= 1'b0;
      w85_q <= 1'b0;
      run_q <= '0;
      hcnt_q <= '0;
      for (int i = 0; i < fwm_pkg::HIST_DEPTH; i++) hist_q[i] <= '0;
    end else if (ce) begin
      ds_q <= ds_d;
      w84_q <= w84_d;
      w85_q <= w85_d;
      run_q <= run_d;
      hcnt_q <= hcnt_d;
      for (int i = 0; i < fwm_pkg::HIST_DEPTH; i++) hist_q[i] <= hist_d[i];
    end
  end

  // Indicator and flag outputs, registered
  logic [6:0] out_d, out_q;
  logic link_lost;
  assign link_lost = s_mhalt || s_cable;
  always_comb begin
    out_d[0] = s_uperr || (s_halt && s_run) ||
               ctrl_q[fwm_pkg::CTRL_INHIBIT_BIT];
    out_d[1] = !(s_mhalt || s_dup || s_cable ||
                 set_err || s_uperr);
    if (set_err || s_rxerr) out_d[2] = 1'b1;
    else out_d[2] = mismatch && blink_q;
    out_d[3] = w84_q || w85_q;
    out_d[4] = (ds_q == fwm_pkg::FWM_LINK_DEAD);
    out_d[5] = link_lost;
    out_d[6] = (ds_q == fwm_pkg::FWM_LINK_DEAD);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) out_q <= '0;
    else if (ce) out_q <= out_d;
  end
  assign {rs485_stop, link_disc, alarm_flag, warning_flag, link_err_led,
          link_run_led, motor_stop} = out_q;

  // AHB-Lite slave, zero wait states
  logic wr_q, wr_d;
  logic [7:0] wa_q, wa_d;
  logic [31:0] rd_q, rd_d, status;
  logic take;
  assign take = hsel && htrans[1] && hready;
  assign status = {22'h0, w85_q, w84_q, link_disc, mismatch, set_err,
                   link_err_led, link_run_led, motor_stop, alarm_flag,
                   warning_flag};
  assign hclr = wr_q && (wa_q == fwm_pkg::OFS_CTRL) &&
                hwdata[fwm_pkg::CTRL_HCLR_BIT];
  always_comb begin
    wr_d = take && hwrite;
    wa_d = take ? {haddr[7:2], 2'h0} : wa_q;
    rd_d = '0;
    ctrl_d = ctrl_q;
    if (wr_q && wa_q == fwm_pkg::OFS_CTRL) begin
      ctrl_d = hwdata;
      ctrl_d[fwm_pkg::CTRL_HCLR_BIT] = 1'b0;
      ctrl_d[31:2] = '0;
    end
    if (take && !hwrite) begin
      unique case (1'b1)
        haddr[7:0] == fwm_pkg::OFS_CTRL: rd_d = ctrl_q;
        haddr[7:0] == fwm_pkg::OFS_STATUS: rd_d = status;
        haddr[7:0] == fwm_pkg::OFS_HCNT: rd_d = {28'h0, hcnt_q};
        haddr[7:0] == fwm_pkg::OFS_SWITCH: rd_d = {20'h0, sw_q};
        haddr[7:0] == fwm_pkg::OFS_ALARM:
          rd_d = alarm_flag ? {24'h0, fwm_pkg::ACODE_ERR} : '0;
        default: begin
          for (int i = 0; i < fwm_pkg::HIST_DEPTH; i++)
            if (haddr[7:0] == fwm_pkg::OFS_HIST0 + 8'(4 * i))
              rd_d = {24'h0, hist_q[i]};
        end
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= '0;
      rd_q <= '0;
      ctrl_q <= fwm_pkg::CTRL_RESET;
    end else if (ce) begin
      wr_q <= wr_d;
      wa_q <= wa_d;
      rd_q <= rd_d;
      ctrl_q <= ctrl_d;
    end
  end
  assign hrdata = rd_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !ce);
  upfault_stop_a: assert property (s_uperr |=> motor_stop)
    else $error("Upstream error did not stop motors");
  halt_stop_a: assert property (s_halt && s_run |=> motor_stop)
    else $error("Program halt did not stop motors");
  run_off_a: assert property ((s_mhalt || s_dup || s_cable) |=>
    !link_run_led) else $error("Run indicator on during link fault");
  set_err_a: assert property (set_err |=> link_err_led &&
    !link_run_led) else $error("Setting error not shown");
  rxerr_lit_a: assert property (s_rxerr |=> link_err_led)
    else $error("Receive error not lit");
  warn_flag_a: assert property (ds_err && ds_q == fwm_pkg::FWM_LINK_IDLE &&
    run_q == 2'h0 |=> ##1 warning_flag)
    else $error("Warning flag not raised");
  warn_clear_a: assert property (ds_ok && !ds_fail &&
    ds_q == fwm_pkg::FWM_LINK_IDLE |=> !w84_q && !w85_q)
    else $error("Warning did not clear");
  hist_push_a: assert property (push |=> hist_q[0] == $past(push_code) &&
    hist_q[1] == $past(hist_q[0]))
    else $error("History not pushed newest first");
  escalate_a: assert property (ds_fail && run_q == 2'h2 &&
    ds_q == fwm_pkg::FWM_LINK_IDLE |=> ##1 (rs485_stop && alarm_flag)[*3])
    else $error("Alarm not raised after three errors");
  linkloss_a: assert property (link_lost && ds_q ==
    fwm_pkg::FWM_LINK_IDLE && !ds_fail |=> link_disc && !alarm_flag)
    else $error("Link loss handled wrongly");
  latch_hold_a: assert property (latched_q |=> $stable(sw_q))
    else $error("Latched switches changed");
  cov_escalate_c: cover property (ds_q == fwm_pkg::FWM_LINK_DEAD);
  cov_blink_c: cover property (mismatch && $rose(link_err_led));
  cov_hist_full_c: cover property (hcnt_q == 4'(fwm_pkg::HIST_DEPTH));
  cov_clear_c: cover property (hclr && hcnt_q != 4'h0);
endmodule : fwm_monitor

//--- tb/fwm_partner.sv
// Downstream link engine and driver model facing the monitor
`timescale 1ns/1ps
module fwm_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  input wire logic [1:0] req_code,
  input wire logic slow,
  input wire logic alarm_flag,
  input wire logic link_disc,
  input wire logic motor_on,
  output logic ds_ok,
  output logic ds_err,
  output logic ds_timeout,
  output logic drv_conv_alm,
  output logic drv_bus_alm,
  output logic drv_tmo_alm
);
  logic [2:0] ev_q, ev_d, late_q;
  logic bus_alm_q, bus_alm_d;
  always_comb begin
    ev_d = 3'h0;
    if (req && req_code != 2'h3) begin
      // Code 0 good answer, 1 transaction error, 2 cycle elapsed
      ev_d[req_code] = 1'b1;
    end
    // Latched until the converter's reset clears it
    bus_alm_d = bus_alm_q | (link_disc & motor_on);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_q <= 3'h0;
      late_q <= 3'h0;
      bus_alm_q <= 1'b0;
    end else begin
      ev_q <= ev_d;
      late_q <= ev_q;
      bus_alm_q <= bus_alm_d;
    end
  end
  // A slow driver answers one cycle later
  assign {ds_timeout, ds_err, ds_ok} = slow ? late_q : ev_q;
  assign drv_conv_alm = alarm_flag;
  assign drv_bus_alm = bus_alm_q;
  // The driver keeps its own supply, so the converter's reset leaves this
  // alarm standing; an open request stands for traffic in flight
  logic tmo_alm_q = 1'b0;
  always @(posedge hclk) begin
    if (!hresetn && req) tmo_alm_q <= 1'b1;
  end
  assign drv_tmo_alm = tmo_alm_q;
endmodule : fwm_partner

//--- tb/fwm_monitor_tb.sv
// Self-checking bench for the fault and warning monitor
`timescale 1ns/1ps
module fwm_monitor_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, req = 0, slow = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, req_code = 0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, drv_conv_alm, drv_bus_alm, drv_tmo_alm;
  logic [3:0] baud_sw = 4'h2, stn_tens_sw = 4'h1, stn_ones_sw = 4'h2;
  logic up_comm_err = 0, plc_halt = 0, sys_running = 0, master_halt = 0;
  logic dup_station = 0, cable_fault = 0, rx_err = 0;
  logic ds_ok, ds_err, ds_timeout, motor_stop, link_run_led, link_err_led;
  logic warning_flag, alarm_flag, link_disc, rs485_stop;
  int error_cnt = 0, n_checks = 0;
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  fwm_monitor #(.BLINK_CYC(4)) fwm_monitor_i (.hclk, .hresetn, .ce(1'b1),
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .baud_sw, .stn_tens_sw, .stn_ones_sw,
    .up_comm_err, .plc_halt, .sys_running, .master_halt, .dup_station,
    .cable_fault, .rx_err, .ds_ok, .ds_err, .ds_timeout, .motor_stop,
    .link_run_led, .link_err_led, .warning_flag, .alarm_flag, .link_disc,
    .rs485_stop);
  fwm_partner fwm_partner_i (.hclk, .hresetn, .req, .req_code, .slow,
    .alarm_flag, .link_disc, .motor_on(sys_running & ~motor_stop), .ds_ok,
    .ds_err, .ds_timeout, .drv_conv_alm, .drv_bus_alm, .drv_tmo_alm);
  task automatic wrap_up;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : wt
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(hresp, 1'b0);
  endtask : rchk
  task automatic pulse(input logic [1:0] c);
    @(posedge hclk);
    req <= 1'b1;
    req_code <= c;
    @(posedge hclk);
    req <= 1'b0;
    wt(4);
  endtask : pulse
  task automatic por(input logic [11:0] sw);
    @(posedge hclk);
    hresetn <= 1'b0;
    {baud_sw, stn_tens_sw, stn_ones_sw} <= sw;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    wt(8);
  endtask : por
  task automatic t_idle;
    chk({motor_stop, link_run_led, link_err_led, warning_flag}, 4'h4);
    rchk(fwm_pkg::OFS_STATUS, 32'h8);
    rchk(fwm_pkg::OFS_SWITCH, 32'h212);
    rchk(fwm_pkg::OFS_HCNT, 32'h0);
    rchk(8'h14, 32'h0);
    chk(drv_tmo_alm, 1'b0);
  endtask : t_idle
  task automatic t_upstream;
    @(posedge hclk);
    up_comm_err <= 1'b1;
    wt(4);
    chk({motor_stop, link_run_led}, 2'b10);
    @(posedge hclk);
    up_comm_err <= 1'b0;
    sys_running <= 1'b1;
    plc_halt <= 1'b1;
    wt(4);
    chk(motor_stop, 1'b1);
    @(posedge hclk);
    sys_running <= 1'b0;
    wt(4);
    chk(motor_stop, 1'b0);
    @(posedge hclk);
    plc_halt <= 1'b0;
    sys_running <= 1'b1;
  endtask : t_upstream
  task automatic t_link;
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      {master_halt, dup_station, cable_fault} <= 3'b100 >> i;
      wt(4);
      chk({link_run_led, link_disc, alarm_flag}, {i == 3, i == 0 || i == 2,
        1'b0});
    end
    chk(drv_bus_alm, 1'b1);
  endtask : t_link
  task automatic t_rx;
    @(posedge hclk);
    rx_err <= 1'b1;
    wt(4);
    repeat (10) begin
      chk(link_err_led, 1'b1);
      wt(1);
    end
    @(posedge hclk);
    rx_err <= 1'b0;
  endtask : t_rx
  task automatic t_warn;
    pulse(2'h1);
    chk({warning_flag, motor_stop}, 2'b10);
    rchk(fwm_pkg::OFS_STATUS, 32'h109);
    pulse(2'h2);
    rchk(fwm_pkg::OFS_STATUS, 32'h309);
    rchk(fwm_pkg::OFS_HIST0, 32'h85);
    rchk(fwm_pkg::OFS_HIST0 + 8'h4, 32'h84);
    pulse(2'h0);
    chk(warning_flag, 1'b0);
    repeat (9) begin
      pulse(2'h1);
      pulse(2'h0);
    end
    rchk(fwm_pkg::OFS_HCNT, 32'ha);
    rchk(fwm_pkg::OFS_HIST0 + 8'h24, 32'h85);
    bus(1'b1, fwm_pkg::OFS_CTRL, 32'h1);
    rchk(fwm_pkg::OFS_HCNT, 32'h0);
    rchk(fwm_pkg::OFS_CTRL, 32'h0);
    bus(1'b1, fwm_pkg::OFS_CTRL, 32'h2);
    wt(2);
    chk(motor_stop, 1'b1);
    rchk(fwm_pkg::OFS_CTRL, 32'h2);
    bus(1'b1, fwm_pkg::OFS_CTRL, 32'h0);
    wt(2);
    chk(motor_stop, 1'b0);
  endtask : t_warn
  task automatic t_blink;
    int ones;
    ones = 0;
    @(posedge hclk);
    baud_sw <= 4'h3;
    wt(4);
    repeat (20) begin
      ones += int'(link_err_led === 1'b1);
      wt(1);
    end
    chk(ones >= 8 && ones <= 12, 1'b1);
    @(posedge hclk);
    baud_sw <= 4'h2;
    wt(12);
    chk(link_err_led, 1'b0);
  endtask : t_blink
  task automatic t_alarm;
    slow <= 1'b1;
    repeat (3) pulse(2'h1);
    chk({alarm_flag, rs485_stop, warning_flag}, 3'b110);
    chk(drv_conv_alm, 1'b1);
    rchk(fwm_pkg::OFS_ALARM, 32'h84);
    pulse(2'h0);
    chk(rs485_stop, 1'b1);
    slow <= 1'b0;
    // An open request with no answer stands for traffic cut by power loss
    req <= 1'b1;
    req_code <= 2'h3;
    por(12'h212);
    req <= 1'b0;
    chk(drv_tmo_alm, 1'b1);
    rchk(fwm_pkg::OFS_HCNT, 32'h0);
    chk({alarm_flag, rs485_stop}, 2'b00);
    chk(drv_conv_alm, 1'b0);
  endtask : t_alarm
  task automatic t_switches;
    logic [11:0] sw [5] = '{12'h512, 12'h265, 12'h200, 12'h21a, 12'h464};
    for (int i = 0; i < 5; i++) begin
      por(sw[i]);
      chk({link_run_led, link_err_led}, i == 4 ? 2'b10 : 2'b01);
    end
  endtask : t_switches
  initial begin
    por(12'h212);
    t_idle();
    t_upstream();
    t_link();
    t_rx();
    t_warn();
    t_blink();
    t_alarm();
    t_switches();
    wrap_up();
  end
  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end
endmodule : fwm_monitor_tb
